/* File: include/nds_pkg.sv */
// Purpose: shared constants and types for the divide sequencer
// Assumes: 16-bit words, eight general registers
// Notes:   states are listed here so the bench can name them
package nds_pkg;
   // ---------------------------------------------------------------
   // constants
   // ---------------------------------------------------------------
   localparam int          DATA_W     = 16;
   localparam int          REM_W      = 18;
   localparam int          GR_AW      = 3;
   localparam logic [3:0]  STEP_INIT  = 4'hF;      // octal 17
   localparam logic [15:0] MOST_NEG   = 16'h8000;
   localparam logic [15:0] WORD_ZERO  = 16'h0000;
   localparam int          SIGN_BIT   = 15;
   localparam int          PAIR_BIT   = 0;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] dividend_hi;
      logic [15:0] dividend_lo;
      logic [15:0] divisor;
      logic [2:0]  reg_sel;
   } nds_op_t;

   typedef struct packed {
      logic n;
      logic z;
      logic v;
      logic c;
   } nds_cc_t;

   typedef struct packed {
      logic        en;
      logic [2:0]  addr;
      logic [15:0] data;
   } nds_gr_wr_t;

   typedef enum logic [3:0] {
      st_idle,
      st_check,
      st_setup,
      st_dividend_negate,
      st_neg_carry,
      st_neg_hi,
      st_neg_test,
      st_first,
      st_loop,
      st_result_correction,
      st_rem_fix,
      st_rem_cpl,
      st_rem_final,
      st_quo_store
   } nds_state_t;
endpackage

/* File: verilog/nds_divider.sv */
// Purpose: signed 32-by-16 non-restoring divide sequencer, one state per clock
// Assumes: start_in is a one-cycle pulse while busy_out is low
// Notes:   results leave as general-register writes and condition codes
//
// Function
// - divisor held in divisor register; dividend high and low words in their registers
// - each step shifts dividend left, new quotient bit enters low end
// - loop always works on a non-negative dividend; divisor may be either sign
// - zero divisor aborts and sets carry, overflow and zero flags
// - branches use flags loaded one state earlier
// - low word negated in one state as zero minus low word
// - low-word carry becomes a 1, applied to the upper word complement
// - dividend still negative after negation aborts the divide
// - no underflow on first cycle means overflow and abort
// - subtract when divisor sign and quotient lsb differ, else add
// - carry out of the top bit is the new quotient bit
// - after fifteen loop steps remainder is written, then branch on correction
// - final quotient bit zero means remainder corrected by divisor magnitude
// - remainder complement prepared without disturbing the remainder
// - negative original dividend stores the complemented remainder
// - quotient stored as is for equal signs, negated for differing signs
// - negated quotient equal to most negative value is a divide error
`timescale 1ns/10ps
`default_nettype none

module nds_divider (
   input  wire logic               clk_in,
   input  wire logic               sys_rst_in,
   input  wire logic               start_in,
   input  wire nds_pkg::nds_op_t   op_in,
   output var  logic               busy_out,
   output var  logic               done_out,
   output var  logic               error_out,
   output var  nds_pkg::nds_gr_wr_t gr_wr_out,
   output var  nds_pkg::nds_cc_t   cc_out
);
   // ---------------------------------------------------------------
   // state and registers
   // ---------------------------------------------------------------
   nds_pkg::nds_state_t  state_reg;
   nds_pkg::nds_state_t  state_next;
   logic [15:0]          divisor_holding_reg;
   logic [15:0]          divisor_holding_next;
   logic [17:0]          upper_dividend_reg;
   logic [17:0]          upper_dividend_next;
   logic [15:0]          lower_dividend_quotient_reg;
   logic [15:0]          lower_dividend_quotient_next;
   logic [15:0]          neg_lo_reg;
   logic [15:0]          neg_lo_next;
   logic [15:0]          rem_cpl_reg;
   logic [15:0]          rem_cpl_next;
   logic [3:0]           step_counter_reg;
   logic [3:0]           step_counter_next;
   logic [2:0]           reg_sel_reg;
   logic [2:0]           reg_sel_next;
   nds_pkg::nds_cc_t     cc_reg;
   nds_pkg::nds_cc_t     cc_next;
   nds_pkg::nds_gr_wr_t  gr_wr_reg;
   nds_pkg::nds_gr_wr_t  gr_wr_next;
   logic                 busy_reg;
   logic                 busy_next;
   logic                 done_reg;
   logic                 done_next;
   logic                 error_reg;
   logic                 error_next;

   // ---------------------------------------------------------------
   // datapath decode
   // ---------------------------------------------------------------
   wire        quotient_lsb  = lower_dividend_quotient_reg[0];
   wire        divisor_neg   = divisor_holding_reg[nds_pkg::SIGN_BIT];
   wire [17:0] divisor_ext   = {{2{divisor_neg}}, divisor_holding_reg};
   wire [17:0] shifted_rem   = {upper_dividend_reg[16:0], lower_dividend_quotient_reg[15]};
   // the first step sees a non-negative remainder, as if quotient_lsb were 1
   wire        op_sub        = (state_reg == nds_pkg::st_first) ? ~divisor_neg
                                                                : (quotient_lsb ^ divisor_neg);
   wire [17:0] step_sum      = op_sub ? (shifted_rem - divisor_ext) : (shifted_rem + divisor_ext);
   wire        new_bit       = ~step_sum[17];
   wire [15:0] step_lower    = {lower_dividend_quotient_reg[14:0], new_bit};
   wire [15:0] low_negated   = nds_pkg::WORD_ZERO - lower_dividend_quotient_reg;
   wire        low_carry     = (lower_dividend_quotient_reg == nds_pkg::WORD_ZERO);
   wire [15:0] hi_negated    = (~upper_dividend_reg[15:0]) + {15'h0, lower_dividend_quotient_reg[0]};
   wire [17:0] corr_sum      = divisor_neg ? (upper_dividend_reg - divisor_ext)
                                           : (upper_dividend_reg + divisor_ext);
   wire [15:0] rem_negated   = nds_pkg::WORD_ZERO - upper_dividend_reg[15:0];
   wire        signs_differ  = cc_reg.n ^ divisor_neg;
   wire [15:0] quo_negated   = nds_pkg::WORD_ZERO - lower_dividend_quotient_reg;
   wire [15:0] quo_final     = signs_differ ? quo_negated : lower_dividend_quotient_reg;
   wire        quo_bad       = signs_differ && (quo_negated == nds_pkg::MOST_NEG);
   wire [15:0] rem_final     = cc_reg.n ? rem_cpl_reg : upper_dividend_reg[15:0];
   wire [2:0]  even_addr     = {reg_sel_reg[2:1], 1'b0};
   wire [2:0]  odd_addr      = reg_sel_reg | 3'h1;

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_comb begin
      state_next                   = state_reg;
      divisor_holding_next         = divisor_holding_reg;
      upper_dividend_next          = upper_dividend_reg;
      lower_dividend_quotient_next = lower_dividend_quotient_reg;
      neg_lo_next                  = neg_lo_reg;
      rem_cpl_next                 = rem_cpl_reg;
      step_counter_next            = step_counter_reg;
      reg_sel_next                 = reg_sel_reg;
      cc_next                      = cc_reg;
      gr_wr_next                   = '0;
      busy_next                    = busy_reg;
      done_next                    = 1'b0;
      error_next                   = 1'b0;
      case (state_reg)
         nds_pkg::st_idle: begin
            if (start_in) begin
               divisor_holding_next         = op_in.divisor;
               upper_dividend_next          = {2'b00, op_in.dividend_hi};
               lower_dividend_quotient_next = op_in.dividend_lo;
               reg_sel_next                 = op_in.reg_sel;
               busy_next                    = 1'b1;
               state_next                   = nds_pkg::st_check;
            end
         end
         nds_pkg::st_check: begin
            // flags loaded here are what the next state branches on
            cc_next.n  = upper_dividend_reg[nds_pkg::SIGN_BIT];
            cc_next.z  = (divisor_holding_reg == nds_pkg::WORD_ZERO);
            state_next = nds_pkg::st_setup;
         end
         nds_pkg::st_setup: begin
            if (cc_reg.z) begin
               cc_next    = '{n: 1'b0, z: 1'b1, v: 1'b1, c: 1'b1};
               error_next = 1'b1;
               busy_next  = 1'b0;
               state_next = nds_pkg::st_idle;
            end else if (cc_reg.n) begin
               state_next = nds_pkg::st_dividend_negate;
            end else begin
               step_counter_next = nds_pkg::STEP_INIT;
               state_next        = nds_pkg::st_first;
            end
         end
         nds_pkg::st_dividend_negate: begin
            neg_lo_next                  = low_negated;
            lower_dividend_quotient_next = {15'h0, low_carry};
            state_next                   = nds_pkg::st_neg_hi;
         end
         nds_pkg::st_neg_hi: begin
            upper_dividend_next          = {2'b00, hi_negated};
            lower_dividend_quotient_next = neg_lo_reg;
            state_next                   = nds_pkg::st_neg_test;
         end
         nds_pkg::st_neg_test: begin
            if (upper_dividend_reg[nds_pkg::SIGN_BIT]) begin
               cc_next.v  = 1'b1;
               error_next = 1'b1;
               busy_next  = 1'b0;
               state_next = nds_pkg::st_idle;
            end else begin
               step_counter_next = nds_pkg::STEP_INIT;
               state_next        = nds_pkg::st_first;
            end
         end
         nds_pkg::st_first: begin
            if (new_bit) begin
               cc_next.v  = 1'b1;
               error_next = 1'b1;
               busy_next  = 1'b0;
               state_next = nds_pkg::st_idle;
            end else begin
               upper_dividend_next          = step_sum;
               lower_dividend_quotient_next = step_lower;
               state_next                   = nds_pkg::st_loop;
            end
         end
         nds_pkg::st_loop: begin
            upper_dividend_next          = step_sum;
            lower_dividend_quotient_next = step_lower;
            step_counter_next            = step_counter_reg - 4'h1;
            if (step_counter_reg == 4'h1) begin
               state_next = nds_pkg::st_result_correction;
            end
         end
         nds_pkg::st_result_correction: begin
            gr_wr_next = '{en: 1'b1, addr: odd_addr, data: upper_dividend_reg[15:0]};
            state_next = quotient_lsb ? nds_pkg::st_rem_cpl : nds_pkg::st_rem_fix;
         end
         nds_pkg::st_rem_fix: begin
            upper_dividend_next = corr_sum;
            state_next          = nds_pkg::st_rem_cpl;
         end
         nds_pkg::st_rem_cpl: begin
            rem_cpl_next = rem_negated;
            state_next   = nds_pkg::st_rem_final;
         end
         nds_pkg::st_rem_final: begin
            gr_wr_next = '{en: 1'b1, addr: odd_addr, data: rem_final};
            state_next = nds_pkg::st_quo_store;
         end
         nds_pkg::st_quo_store: begin
            busy_next  = 1'b0;
            state_next = nds_pkg::st_idle;
            if (quo_bad) begin
               cc_next.v  = 1'b1;
               error_next = 1'b1;
            end else begin
               gr_wr_next = '{en: 1'b1, addr: even_addr, data: quo_final};
               cc_next    = '{n: quo_final[nds_pkg::SIGN_BIT], z: (quo_final == nds_pkg::WORD_ZERO),
                              v: 1'b0, c: 1'b0};
               done_next  = 1'b1;
            end
         end
         default: begin
            busy_next  = 1'b0;
            state_next = nds_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_reg                   <= nds_pkg::st_idle;
         divisor_holding_reg         <= 16'h0000;
         upper_dividend_reg          <= 18'h00000;
         lower_dividend_quotient_reg <= 16'h0000;
         neg_lo_reg                  <= 16'h0000;
         rem_cpl_reg                 <= 16'h0000;
         step_counter_reg            <= 4'h0;
         reg_sel_reg                 <= 3'h0;
         cc_reg                      <= '0;
         gr_wr_reg                   <= '0;
         busy_reg                    <= 1'b0;
         done_reg                    <= 1'b0;
         error_reg                   <= 1'b0;
      end else begin
         state_reg                   <= state_next;
         divisor_holding_reg         <= divisor_holding_next;
         upper_dividend_reg          <= upper_dividend_next;
         lower_dividend_quotient_reg <= lower_dividend_quotient_next;
         neg_lo_reg                  <= neg_lo_next;
         rem_cpl_reg                 <= rem_cpl_next;
         step_counter_reg            <= step_counter_next;
         reg_sel_reg                 <= reg_sel_next;
         cc_reg                      <= cc_next;
         gr_wr_reg                   <= gr_wr_next;
         busy_reg                    <= busy_next;
         done_reg                    <= done_next;
         error_reg                   <= error_next;
      end
   end

   assign busy_out  = busy_reg;
   assign done_out  = done_reg;
   assign error_out = error_reg;
   assign gr_wr_out = gr_wr_reg;
   assign cc_out    = cc_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic [4:0] chk_loops_reg;
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || state_reg == nds_pkg::st_first) begin
         chk_loops_reg <= 5'h00;
      end else if (state_reg == nds_pkg::st_loop) begin
         chk_loops_reg <= chk_loops_reg + 5'h01;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   zero_div_abort_a: assert property (state_reg == nds_pkg::st_setup && cc_reg.z |=>
      error_reg && cc_reg.c && cc_reg.v && cc_reg.z && !gr_wr_reg.en)
      else $error("zero divisor did not abort with c v z");
   flag_branch_a: assert property (state_reg == nds_pkg::st_check ##1 !cc_reg.z && cc_reg.n |=>
      state_reg == nds_pkg::st_dividend_negate)
      else $error("negative dividend not routed to negation");
   low_negate_a: assert property (state_reg == nds_pkg::st_dividend_negate |-> ##2
      lower_dividend_quotient_reg == 16'h0000 - $past(lower_dividend_quotient_reg, 2))
      else $error("low word negation wrong");
   hi_negate_a: assert property (state_reg == nds_pkg::st_dividend_negate |-> ##2
      upper_dividend_reg[15:0] == (~$past(upper_dividend_reg[15:0], 2))
                                  + {15'h0, $past(lower_dividend_quotient_reg, 2) == 16'h0000})
      else $error("upper word negation wrong");
   min_neg_abort_a: assert property (state_reg == nds_pkg::st_neg_test && upper_dividend_reg[15] |=>
      error_reg && state_reg == nds_pkg::st_idle)
      else $error("most negative dividend not aborted");
   first_entry_a: assert property (state_reg == nds_pkg::st_first |->
      step_counter_reg == nds_pkg::STEP_INIT && !upper_dividend_reg[15])
      else $error("first cycle entered badly");
   first_ovf_a: assert property (state_reg == nds_pkg::st_first && new_bit |=>
      error_reg && !gr_wr_reg.en ##1 !gr_wr_reg.en)
      else $error("first cycle overflow missed");
   loop_shift_a: assert property (state_reg == nds_pkg::st_loop |=>
      lower_dividend_quotient_reg[15:1] == $past(lower_dividend_quotient_reg[14:0])
      && lower_dividend_quotient_reg[0] == !$past(step_sum[17]))
      else $error("loop shift or quotient bit wrong");
   loop_count_a: assert property (state_reg == nds_pkg::st_result_correction |->
      chk_loops_reg == 5'h0F && gr_wr_next.en && gr_wr_next.addr == odd_addr)
      else $error("remainder store not after fifteen steps");
   quo_error_a: assert property (state_reg == nds_pkg::st_quo_store && quo_bad |=>
      error_reg && !gr_wr_reg.en)
      else $error("most negative quotient accepted");
   quo_pair_a: assert property (state_reg == nds_pkg::st_quo_store && !quo_bad |=>
      gr_wr_reg.en && gr_wr_reg.addr[0] == 1'b0 && gr_wr_reg.data == $past(quo_final) && done_reg)
      else $error("quotient write wrong");

   zero_div_c: cover property (state_reg == nds_pkg::st_setup && cc_reg.z);
   neg_ok_c:   cover property (state_reg == nds_pkg::st_neg_test && !upper_dividend_reg[15]);
   ovf_c:      cover property (state_reg == nds_pkg::st_first && new_bit);
   fix_c:      cover property (state_reg == nds_pkg::st_rem_fix);
   done_c:     cover property (done_reg && signs_differ);
endmodule

`default_nettype wire

/* File: tb/nds_gr_file_model.sv */
// Purpose: general register file on the far side of the divide sequencer
// Assumes: one write port driven by the sequencer, eight 16-bit registers
// Notes:   registers come up holding a fill pattern so a missing write shows
`timescale 1ns/10ps
`default_nettype none

module nds_gr_file_model (
   input  wire logic                clk_in,
   input  wire logic                sys_rst_in,
   input  wire nds_pkg::nds_gr_wr_t gr_wr_in,
   output var  logic [15:0]         gr_out [8]
);
   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         for (int i = 0; i < 8; i++) begin
            gr_out[i] <= 16'hA5A5;
         end
      end else if (gr_wr_in.en) begin
         gr_out[gr_wr_in.addr] <= gr_wr_in.data;
      end
   end
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: self-checking bench for the divide sequencer
// Assumes: inputs driven 1 ns after the rising edge
// Notes:   expected results come from plain signed integer division
`timescale 1ns/10ps
`default_nettype none

module testbench;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic                clk_in     = 1'b0;
   logic                sys_rst_in = 1'b1;
   logic                start_in   = 1'b0;
   nds_pkg::nds_op_t    op_in      = '0;
   logic                busy_out;
   logic                done_out;
   logic                error_out;
   nds_pkg::nds_gr_wr_t gr_wr_out;
   nds_pkg::nds_cc_t    cc_out;
   logic [15:0]         gr [8];
   int                  n_fail     = 0;
   int                  compares   = 0;
   int                  cycles     = 0;
   int                  n_qwr;
   int                  lat;

   always #2.5 clk_in = ~clk_in;

   nds_divider i_dut (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .start_in   (start_in),
      .op_in      (op_in),
      .busy_out   (busy_out),
      .done_out   (done_out),
      .error_out  (error_out),
      .gr_wr_out  (gr_wr_out),
      .cc_out     (cc_out)
   );

   nds_gr_file_model i_gr (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .gr_wr_in   (gr_wr_out),
      .gr_out     (gr)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // a poke raises start mid-run with a zero divisor, which must be ignored
   task automatic run(input logic [31:0] dvd, input logic [15:0] dvs, input logic [2:0] sel, input bit poke);
      op_in = '{dividend_hi: dvd[31:16], dividend_lo: dvd[15:0], divisor: dvs, reg_sel: sel};
      start_in = 1'b1;
      @(posedge clk_in);
      #1;
      n_qwr = 0;
      for (lat = 1; lat < 60; lat++) begin
         start_in = poke && (lat == 5);
         if (poke && lat == 5) begin
            op_in.divisor = 16'h0000;
         end
         @(posedge clk_in);
         #1;
         if (lat == 1) check(busy_out, 1'b1, "busy after start");
         if (gr_wr_out.en === 1'b1 && gr_wr_out.addr === {sel[2:1], 1'b0}) n_qwr++;
         if (done_out === 1'b1 || error_out === 1'b1) break;
      end
   endtask

   task automatic expect_div(input logic [31:0] dvd, input logic [15:0] dvs, input logic [2:0] sel, input bit poke);
      longint a;
      longint b;
      longint q;
      longint r;
      bit     bad;
      int     base;
      a = longint'($signed(dvd));
      b = longint'($signed(dvs));
      q = 0;
      r = 0;
      bad = (b == 0) || (dvd == 32'h8000_0000);
      if (!bad) begin
         q = a / b;
         r = a % b;
         bad = (q > 32767) || (q < -32767);
      end
      // a negative dividend costs three extra negation states
      base = (a < 0) ? 25 : 22;
      run(dvd, dvs, sel, poke);
      check(busy_out, 1'b0, "idle at finish");
      if (bad) begin
         check(error_out, 1'b1, "abort flagged");
         check(n_qwr, 0, "quotient withheld");
         check(cc_out.v, 1'b1, "overflow flag");
         if (b == 0) begin
            check(lat, 2, "zero divisor latency");
            check(cc_out[2:0], 3'h7, "zero divisor flags");
         end
      end else begin
         check(done_out, 1'b1, "done");
         check(lat >= base && lat <= base + 1, 1'b1, "latency");
         check(n_qwr, 1, "one quotient write");
         check(gr_wr_out.addr, {sel[2:1], 1'b0}, "quotient address");
         check(gr_wr_out.data, q[15:0], "quotient");
         check(gr[{sel[2:1], 1'b1}], r[15:0], "remainder");
         check(cc_out, {q[15], q[15:0] == 16'h0000, 2'h0}, "result flags");
      end
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_signs();
      logic [31:0] dd [8] = '{32'h0000_0064, 32'hFFFF_FF9C, 32'h0000_0064, 32'hFFFF_FF9C,
                              32'h0000_0054, 32'h0001_7FFF, 32'hFFFE_8001, 32'h0000_0000};
      logic [15:0] dv [8] = '{16'h0007, 16'h0007, 16'hFFF9, 16'hFFF9,
                              16'h0007, 16'h0003, 16'h0003, 16'h0005};
      for (int i = 0; i < 8; i++) begin
         expect_div(dd[i], dv[i], i[2:0], 1'b0);
      end
      $display("sign combinations test done");
   endtask

   task automatic t_errors();
      logic [31:0] dd [6] = '{32'h0000_0064, 32'h8000_0000, 32'h0001_0000,
                              32'h0000_8000, 32'h0000_8000, 32'hFFFF_8000};
      logic [15:0] dv [6] = '{16'h0000, 16'h0003, 16'h0001, 16'h0001, 16'hFFFF, 16'h0001};
      for (int i = 0; i < 6; i++) begin
         expect_div(dd[i], dv[i], 3'h2, 1'b0);
      end
      $display("abort test done");
   endtask

   task automatic t_refuse();
      expect_div(32'h0000_03E8, 16'h000B, 3'h5, 1'b1);
      expect_div(32'hFFFF_FC18, 16'h000B, 3'h1, 1'b1);
      $display("busy refusal test done");
   endtask

   task automatic t_reset();
      op_in = '{dividend_hi: 16'h0000, dividend_lo: 16'h0064, divisor: 16'h0007, reg_sel: 3'h0};
      start_in = 1'b1;
      @(posedge clk_in);
      #1 start_in = 1'b0;
      repeat (6) @(posedge clk_in);
      #1 sys_rst_in = 1'b1;
      repeat (2) @(posedge clk_in);
      #1;
      check({busy_out, done_out, error_out, gr_wr_out.en, cc_out}, 8'h00, "outputs in reset");
      sys_rst_in = 1'b0;
      expect_div(32'h0000_0064, 16'h0007, 3'h6, 1'b0);
      $display("mid-run reset test done");
   endtask

   // ---------------------------------------------------------------
   // main sequence and hang guard
   // ---------------------------------------------------------------
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         give_verdict();
      end
   end

   initial begin
      repeat (2) @(posedge clk_in);
      #1 sys_rst_in = 1'b0;
      t_signs();
      t_errors();
      t_refuse();
      t_reset();
      give_verdict();
   end
endmodule

`default_nettype wire
